// [design/sacp_params.svh]
// Purpose: shared constants of the step attenuator control port
// Assumes: included by bare name; the system clock runs at 25 MHz
// Notes: device limits stay in ns, cycle counts derive from them
`ifndef SACP_PARAMS_SVH
`define SACP_PARAMS_SVH

// System clock period in ns
`define SACP_CLK_NS 40
// Mode pin to first serial clock or parallel latch, least time in ns
`define SACP_MODE_SETUP_NS 100
`define SACP_MODE_SETUP_CYC \
	((`SACP_MODE_SETUP_NS + `SACP_CLK_NS - 1) / `SACP_CLK_NS)
// Latch strobe pulse, least width in ns
`define SACP_LE_MIN_NS 10
`define SACP_LE_MIN_CYC ((`SACP_LE_MIN_NS + `SACP_CLK_NS - 1) / `SACP_CLK_NS)
// Serial clock half period made by the host, in system cycles
`define SACP_SCLK_HALF_CYC 4
// Strobe high hold lasts a half period; never shorter than the least width
`define SACP_LE_HOLD_CYC \
	((`SACP_SCLK_HALF_CYC > `SACP_LE_MIN_CYC) ? \
	`SACP_SCLK_HALF_CYC : `SACP_LE_MIN_CYC)
// Host sequencer counter width
`define SACP_CNT_W 4

// Frame layout: attenuation word in Q7..Q0, address word in Q15..Q8
`define SACP_FRAME_W 16
`define SACP_WORD_W 8
`define SACP_STEP_W 7
`define SACP_ADDR_LSB 8
`define SACP_ADDR_CMP_W 3
`define SACP_LAST_BIT 15

// Reset values: all seven steps in, address 000
`define SACP_SHIFT_RST 16'h007F
`define SACP_ATTEN_MAX 7'h7F

// Positions inside the device synchroniser vector
`define SACP_SYNC_W 14
`define SACP_SY_SCLK 13
`define SACP_SY_SDATA 12
`define SACP_SY_LE 11
`define SACP_SY_MODE 10
`define SACP_SY_PAR_HI 9
`define SACP_SY_PAR_LO 3
`define SACP_SY_ADDR_HI 2
`define SACP_SY_ADDR_LO 0

`endif

// [design/sacp_pkg.sv]
// Purpose: types shared by both ends of the control port
// Assumes: sacp_params.svh gives the widths
// Notes: host command kinds and host sequencer states
`include "sacp_params.svh"

package sacp_pkg;

	typedef logic [`SACP_FRAME_W-1:0] sacp_frame_t;

	typedef enum logic [1:0] {
		CMD_SERIAL = 2'h0,
		CMD_PAR_LATCH = 2'h1,
		CMD_PAR_DIRECT = 2'h2
	} sacp_cmd_e;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_SETUP = 3'h1,
		H_START = 3'h2,
		H_BIT_LO = 3'h3,
		H_BIT_HI = 3'h4,
		H_LATCH = 3'h5,
		H_HOLD = 3'h6
	} sacp_hstate_e;

endpackage : sacp_pkg

// [design/sacp_if.sv]
// Purpose: pins between host controller and step attenuator
// Assumes: host drives every pin; the mode pin may be released
// Notes: a released mode pin reads high, as an open pin does
`include "sacp_params.svh"
`timescale 1ns/1ps
`default_nettype none

interface sacp_if;
	logic sclk;
	logic sdata;
	logic load_strobe;
	logic mode_sel_out;
	logic mode_sel_oe_n;
	logic mode_sel;
	logic [`SACP_STEP_W-1:0] par_bits;

	// Open mode pin floats high and selects serial
	assign mode_sel = mode_sel_oe_n ? 1'b1 : mode_sel_out;

	modport host (
		output sclk,
		output sdata,
		output load_strobe,
		output mode_sel_out,
		output mode_sel_oe_n,
		output par_bits,
		input mode_sel
	);

	modport device (
		input sclk,
		input sdata,
		input load_strobe,
		input mode_sel,
		input par_bits
	);
endinterface : sacp_if

`default_nettype wire

// [design/sacp_device.sv]
// Purpose: control logic of a 7-bit step attenuator, serial and parallel
// Assumes: all pins are asynchronous to clk_sys and pass two flip-flops
// Notes: the serial clock is sampled, so it must stay well below clk_sys
//
// Notes on behaviour
// - mode pin high or open selects serial
// - sixteen bit shift register, two words
// - first eight bits attenuation, last eight address
// - compare low three address bits, else hold
// - open address pins read as zero
// - host shares lines among eight addressed devices
// - set bit switches its weighted step in
// - serial reset value is max attenuation, address 000
// - strobe rise loads frame if address matches
// - first bit lands in Q0, last Q15
// - strobe high freezes the shift register
// - host keeps strobe high when idle
// - mode high 100 ns before first clock
// - mode change 100 ns before parallel latch
// - parallel strobe pulse at least 10 ns
// - parallel, strobe high follows inputs directly
// - parallel, strobe low ignores input changes
// - parallel strobe rise loads the inputs
// - parallel strobe fall changes nothing
// - parallel power-up with strobe low is max
// - parallel inputs binary weighted, 0.25 to 16 dB
`include "sacp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sacp_device
	import sacp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	sacp_if.device link,
	input wire logic hard_address_bit0,
	input wire logic hard_address_bit1,
	input wire logic hard_address_bit2,
	output logic [`SACP_STEP_W-1:0] atten_state,
	output logic serial_mode,
	output logic load_pulse,
	output logic addr_miss
);

	// Address check of a captured frame against the strapped pins
	function automatic logic sacp_addr_match(
		input sacp_frame_t frame,
		input logic [`SACP_ADDR_CMP_W-1:0] strap
	);
		sacp_addr_match =
			(frame[`SACP_ADDR_LSB +: `SACP_ADDR_CMP_W] == strap);
	endfunction : sacp_addr_match

	logic [`SACP_SYNC_W-1:0] pin_raw;
	logic [`SACP_SYNC_W-1:0] sync_meta_reg;
	logic [`SACP_SYNC_W-1:0] sync_reg;
	logic sclk_s;
	logic sdata_s;
	logic le_s;
	logic serial_s;
	logic [`SACP_STEP_W-1:0] par_s;
	logic [`SACP_ADDR_CMP_W-1:0] strap_s;
	logic sclk_prev_reg;
	logic le_prev_reg;
	logic [1:0] prime_cnt_reg;
	logic primed;
	logic sclk_rise;
	logic le_rise;
	logic addr_ok;
	sacp_frame_t shift_reg;
	sacp_frame_t shift_next;
	logic [`SACP_STEP_W-1:0] atten_next;

	// Gather every pin into one vector so all share one sync depth
	assign pin_raw = {
		link.sclk,
		link.sdata,
		link.load_strobe,
		link.mode_sel,
		link.par_bits,
		hard_address_bit2,
		hard_address_bit1,
		hard_address_bit0
	};

	// Two-stage synchroniser; only sync_reg reads the first stage
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync_meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			sync_meta_reg <= pin_raw;
			sync_reg <= sync_meta_reg;
		end
	end

	// Field views of the synchronised pins
	assign sclk_s = sync_reg[`SACP_SY_SCLK];
	assign sdata_s = sync_reg[`SACP_SY_SDATA];
	assign le_s = sync_reg[`SACP_SY_LE];
	assign serial_s = sync_reg[`SACP_SY_MODE];
	assign par_s = sync_reg[`SACP_SY_PAR_HI:`SACP_SY_PAR_LO];
	assign strap_s = sync_reg[`SACP_SY_ADDR_HI:`SACP_SY_ADDR_LO];

	// Edge history of serial clock and strobe
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sclk_prev_reg <= 1'b0;
			le_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
			le_prev_reg <= le_s;
		end
	end

	// Hold off edges until the synchroniser holds real pin levels,
	// otherwise a strobe high at power-up looks like a rising edge
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prime_cnt_reg <= 2'h0;
		end else if (prime_cnt_reg != 2'h3) begin
			prime_cnt_reg <= prime_cnt_reg + 2'h1;
		end
	end

	assign primed = (prime_cnt_reg == 2'h3);
	assign sclk_rise = primed & sclk_s & ~sclk_prev_reg;
	assign le_rise = primed & le_s & ~le_prev_reg;
	assign addr_ok = sacp_addr_match(shift_reg, strap_s);

	// Shift register next value
	always_comb begin
		shift_next = shift_reg;
		if (serial_s && !le_s && sclk_rise) begin
			// enter at top, LSB ends Q0
			shift_next = {sdata_s, shift_reg[`SACP_LAST_BIT:1]};
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg <= `SACP_SHIFT_RST;
		end else begin
			shift_reg <= shift_next;
		end
	end

	// Next attenuation state; the top attenuation bit is carried in
	// the frame but has no step behind it
	always_comb begin
		atten_next = atten_state;
		if (primed) begin
			if (serial_s) begin
				if (le_rise && addr_ok) begin
					atten_next = shift_reg[`SACP_STEP_W-1:0];
				end
			end else begin
				if (le_s) begin
					atten_next = par_s;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			atten_state <= `SACP_ATTEN_MAX;
		end else begin
			atten_state <= atten_next;
		end
	end

	// Status pulses: a load took place, or a serial frame was refused
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			load_pulse <= 1'b0;
			addr_miss <= 1'b0;
		end else begin
			load_pulse <= le_rise & (~serial_s | addr_ok);
			addr_miss <= le_rise & serial_s & ~addr_ok;
		end
	end

	// Current interface choice, for observation; held at its reset
	// value until primed, since the zeroed syncs would read as parallel
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			serial_mode <= 1'b1;
		end else if (primed) begin
			serial_mode <= serial_s;
		end
	end

endmodule : sacp_device

`default_nettype wire

// [design/sacp_host.sv]
// Purpose: host side sequencer for the step attenuator control port
// Assumes: one command at a time; serial clock derived from clk_sys
// Notes: strobe rests high between commands, serial clock rests low
`include "sacp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sacp_host
	import sacp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	sacp_if.host link,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_kind,
	input wire logic [`SACP_WORD_W-1:0] cmd_atten,
	input wire logic [`SACP_WORD_W-1:0] cmd_addr,
	output logic cmd_ready,
	output logic cmd_done
);

	sacp_hstate_e state_reg;
	logic [`SACP_CNT_W-1:0] cnt_reg;
	logic [4:0] bit_reg;
	sacp_frame_t frame_reg;
	logic [1:0] kind_reg;
	logic want_serial;

	assign want_serial = (cmd_kind == CMD_SERIAL);

	// Sequencer: mode setup, then bit shifting, a parallel latch or a direct parallel drive
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= H_IDLE;
			cnt_reg <= '0;
			bit_reg <= 5'h00;
			frame_reg <= '0;
			kind_reg <= CMD_SERIAL;
			cmd_ready <= 1'b1;
			cmd_done <= 1'b0;
			link.sclk <= 1'b0;
			link.sdata <= 1'b0;
			link.load_strobe <= 1'b1;
			link.mode_sel_out <= 1'b1;
			link.mode_sel_oe_n <= 1'b1;
			link.par_bits <= '0;
		end else begin
			cmd_done <= 1'b0;
			unique case (state_reg)
				H_IDLE: begin
					if (cmd_valid) begin
						cmd_ready <= 1'b0;
						frame_reg <= {cmd_addr, cmd_atten};
						kind_reg <= cmd_kind;
						bit_reg <= 5'h00;
						// Serial releases the pin, parallel drives it low
						link.mode_sel_oe_n <= want_serial;
						link.mode_sel_out <= 1'b0;
						if (link.mode_sel != want_serial) begin
							state_reg <= H_SETUP;
							cnt_reg <= `SACP_CNT_W'(`SACP_MODE_SETUP_CYC - 1);
						end else begin
							state_reg <= H_START;
						end
					end
				end
				H_SETUP: begin
					if (cnt_reg == '0) begin
						state_reg <= H_START;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				H_START: begin
					cnt_reg <= `SACP_CNT_W'(`SACP_SCLK_HALF_CYC - 1);
					unique case (kind_reg)
						CMD_SERIAL: begin
							link.load_strobe <= 1'b0;
							link.sdata <= frame_reg[0];
							state_reg <= H_BIT_LO;
						end
						CMD_PAR_LATCH: begin
							link.load_strobe <= 1'b0;
							link.par_bits <= frame_reg[`SACP_STEP_W-1:0];
							state_reg <= H_LATCH;
						end
						CMD_PAR_DIRECT: begin
							link.par_bits <= frame_reg[`SACP_STEP_W-1:0];
							cmd_done <= 1'b1;
							cmd_ready <= 1'b1;
							state_reg <= H_IDLE;
						end
						default: begin
							// Unused code: finish here; the mode pin was already driven low in H_IDLE
							cmd_done <= 1'b1;
							cmd_ready <= 1'b1;
							state_reg <= H_IDLE;
						end
					endcase
				end
				H_BIT_LO: begin
					if (cnt_reg == '0) begin
						link.sclk <= 1'b1;
						cnt_reg <= `SACP_CNT_W'(`SACP_SCLK_HALF_CYC - 1);
						state_reg <= H_BIT_HI;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				H_BIT_HI: begin
					if (cnt_reg == '0) begin
						link.sclk <= 1'b0;
						cnt_reg <= `SACP_CNT_W'(`SACP_SCLK_HALF_CYC - 1);
						if (bit_reg == 5'(`SACP_LAST_BIT)) begin
							state_reg <= H_LATCH;
						end else begin
							bit_reg <= bit_reg + 5'h01;
							link.sdata <= frame_reg[4'(bit_reg + 5'h01)];
							state_reg <= H_BIT_LO;
						end
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				H_LATCH: begin
					if (cnt_reg == '0) begin
						link.load_strobe <= 1'b1;
						cnt_reg <= `SACP_CNT_W'(`SACP_LE_HOLD_CYC - 1);
						state_reg <= H_HOLD;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				H_HOLD: begin
					if (cnt_reg == '0) begin
						cmd_done <= 1'b1;
						cmd_ready <= 1'b1;
						state_reg <= H_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: begin
					state_reg <= H_IDLE;
					cmd_ready <= 1'b1;
				end
			endcase
		end
	end

endmodule : sacp_host

`default_nettype wire

// [bench/sacp_checker.sv]
// Purpose: timing and state checks on the control port pins
// Assumes: one clock domain; pins are sampled on clk_sys
// Notes: sees the interface signals and the device outputs only
`include "sacp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sacp_checker (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic load_strobe,
	input wire logic mode_sel,
	input wire logic [`SACP_STEP_W-1:0] par_bits,
	input wire logic [`SACP_STEP_W-1:0] atten_state,
	input wire logic serial_mode,
	input wire logic load_pulse,
	input wire logic addr_miss
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	// Host pin discipline around the serial clock and strobe
	a_idle_clock_low: assert property (load_strobe |-> !sclk)
		else $error("serial clock high while strobe high");
	a_clock_high_hold: assert property ($rose(sclk) |=> sclk [*3])
		else $error("serial clock high phase too short");
	a_clock_low_hold: assert property ($fell(sclk) |=> !sclk [*3])
		else $error("serial clock low phase too short");
	a_data_steady: assert property (sclk |-> $stable(sdata))
		else $error("serial data moved while clock high");
	a_strobe_high_hold: assert property ($rose(load_strobe) |=> load_strobe [*3])
		else $error("strobe pulse too short");
	// Mode change needs setup before any clock or latch
	a_mode_setup_ser: assert property ($rose(mode_sel) |-> !sclk [*3])
		else $error("serial clock too soon after mode rise");
	a_mode_setup_par: assert property ($fell(mode_sel) |-> load_strobe [*3])
		else $error("strobe moved too soon after mode fall");
	// Device state changes only for a good reason
	a_miss_holds: assert property (addr_miss |-> $stable(atten_state) && !load_pulse)
		else $error("state moved on address miss");
	a_serial_loads_only: assert property (serial_mode && $past(serial_mode) && $changed(atten_state) |-> load_pulse)
		else $error("serial state moved without load");
	a_par_strobe_gate: assert property (!serial_mode && $changed(atten_state) |-> $past(load_strobe, 3) || $past(load_strobe, 4))
		else $error("parallel state moved with strobe low");
	// Pins reach the state three samples later through the syncs
	a_par_follow_pins: assert property ($past(load_strobe, 3) && !$past(mode_sel, 3) |-> atten_state == $past(par_bits, 3))
		else $error("parallel state does not follow inputs");

	// Main scenarios reached
	c_serial_load: cover property (serial_mode && load_pulse);
	c_addr_miss: cover property (addr_miss);
	c_par_load: cover property (!serial_mode && load_pulse);
	c_mode_fall: cover property ($fell(mode_sel));
endmodule : sacp_checker

`default_nettype wire

// [bench/tb.sv]
// Purpose: host and device joined, commands checked end to end
// Assumes: straps come from the bench, zero stands for open pins
// Notes: the frame is rebuilt from the wire to check bit order
`include "sacp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
	import sacp_pkg::*;
	logic clk_sys, arst_n, cmd_valid, cmd_ready, cmd_done;
	logic sclk_d = 1'b0;
	logic serial_mode, load_pulse, addr_miss, exp_mode;
	logic [1:0] cmd_kind;
	logic [7:0] cmd_atten, cmd_addr;
	logic [2:0] strap;
	logic [6:0] atten_state, exp_st;
	sacp_frame_t cap = 16'h0000;
	int bad_count, n_compared, seed, r;
	int cycles = 0;
	int n_load = 0;
	int n_miss = 0;

	sacp_if link_if();
	sacp_host sacp_host_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.link(link_if), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_atten(cmd_atten), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
		.cmd_done(cmd_done));
	sacp_device sacp_device_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.link(link_if), .hard_address_bit0(strap[0]),
		.hard_address_bit1(strap[1]), .hard_address_bit2(strap[2]),
		.atten_state(atten_state), .serial_mode(serial_mode),
		.load_pulse(load_pulse), .addr_miss(addr_miss));
	sacp_checker sacp_checker_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.sclk(link_if.sclk), .sdata(link_if.sdata),
		.load_strobe(link_if.load_strobe), .mode_sel(link_if.mode_sel),
		.par_bits(link_if.par_bits), .atten_state(atten_state),
		.serial_mode(serial_mode), .load_pulse(load_pulse),
		.addr_miss(addr_miss));

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Wire monitor: shift on serial clock rise, count pulses, cut hangs
	always @(posedge clk_sys) begin
		sclk_d <= link_if.sclk;
		if (link_if.sclk && !sclk_d && !link_if.load_strobe) begin
			cap <= {link_if.sdata, cap[15:1]};
		end
		if (load_pulse === 1'b1) n_load++;
		if (addr_miss === 1'b1) n_miss++;
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	// Expected state; a miss or a no-op command keeps the old one
	function automatic logic [6:0] exp_state(input logic [1:0] k,
		input logic [7:0] a, input logic [7:0] ad, input logic [2:0] s,
		input logic [6:0] prev);
		if (k == 2'h3) return prev;
		if (k != 2'h0) return a[6:0];
		return (ad[2:0] == s) ? a[6:0] : prev;
	endfunction : exp_state

	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic do_reset();
		arst_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		arst_n = 1'b1;
		exp_st = 7'h7F;
		exp_mode = 1'b1;
		@(negedge clk_sys);
		check("reset state", 16'(atten_state), 16'h007F);
		check("reset mode", 16'(serial_mode), 16'h0001);
	endtask : do_reset

	// One command from take to settled device state
	task automatic do_cmd(input logic [1:0] k, input logic [7:0] a,
		input logic [7:0] ad);
		int i;
		int l0;
		int m0;
		logic [6:0] prev;
		prev = exp_st;
		l0 = n_load;
		m0 = n_miss;
		i = 0;
		while (cmd_ready !== 1'b1 && i < 300) begin
			@(negedge clk_sys);
			i++;
		end
		cmd_kind = k;
		cmd_atten = a;
		cmd_addr = ad;
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		i = 0;
		while (cmd_done !== 1'b1 && i < 300) begin
			@(negedge clk_sys);
			i++;
		end
		check("done", 16'(i < 300), 16'h0001);
		repeat (8) @(negedge clk_sys);
		exp_st = exp_state(k, a, ad, strap, prev);
		if (k != 2'h3) exp_mode = (k == 2'h0);
		check("atten_state", 16'(atten_state), 16'(exp_st));
		check("serial_mode", 16'(serial_mode), 16'(exp_mode));
		check("mode_sel", 16'(link_if.mode_sel), 16'(exp_mode));
		check("loads", 16'(n_load - l0),
			16'((k == 2'h0 && ad[2:0] == strap) || k == 2'h1));
		check("misses", 16'(n_miss - m0),
			16'(k == 2'h0 && ad[2:0] != strap));
		if (k == 2'h0) check("frame", cap, {ad, a});
	endtask : do_cmd

	// Main sequence
	initial begin
		seed = 87;
		bad_count = 0;
		n_compared = 0;
		cmd_valid = 1'b0;
		cmd_kind = 2'h0;
		cmd_atten = 8'h00;
		cmd_addr = 8'h00;
		strap = 3'h0;
		do_reset();
		// open straps, every address tried, upper bits set
		for (int n = 0; n < 8; n++) do_cmd(2'h0, 8'(n * 37 + 128), 8'(n) | 8'hF8);
		// random straps and frames, half aimed at this device
		strap = 3'($random(seed));
		for (int n = 0; n < 8; n++) begin
			r = $random(seed);
			do_cmd(2'h0, r[7:0], n[0] ? {r[15:11], strap} : r[15:8]);
		end
		// each weight alone, latched and direct in turn
		for (int n = 0; n < 7; n++) do_cmd(n[0] ? 2'h2 : 2'h1, 8'(1 << n), 8'h00);
		do_cmd(2'h1, 8'h7F, 8'h00);
		do_cmd(2'h3, 8'h00, 8'h00);
		do_cmd(2'h2, 8'h00, 8'h00);
		// back to serial, then a reset in mid-run
		do_cmd(2'h0, 8'h2A, {5'h00, strap});
		do_cmd(2'h1, 8'h55, 8'h00);
		do_reset();
		do_cmd(2'h0, 8'hFF, {5'h1F, strap});
		stop_test();
	end
endmodule : tb

`default_nettype wire
